// file: common/lpm_params.svh
`ifndef LPM_PARAMS_SVH
`define LPM_PARAMS_SVH

// ----------------------------------------
// Management register addresses
// ----------------------------------------
`define LPM_REG_BASIC 5'h00
`define LPM_REG_DIGITAL 5'h10
`define LPM_REG_AFE 5'h11
`define LPM_REG_PULSE 5'h13
`define LPM_REG_STATUS 5'h14
`define LPM_REG_EXPANDED 5'h18
`define LPM_REG_CTRL2 5'h1f

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LPM_BIT_SOFT_RESET 15
`define LPM_BIT_AUTONEG 12
`define LPM_BIT_POWER_DOWN 11
`define LPM_BIT_PLL_OFF 4
`define LPM_BIT_SLOW_OSC 5
`define LPM_BIT_SLEEP_N 11
`define LPM_BIT_POWER_SAVE 10
`define LPM_BIT_LONG_GAP 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LPM_RST_AUTONEG 1'b1
`define LPM_RST_POWER_DOWN 1'b0
`define LPM_RST_PLL_OFF 1'b0
`define LPM_RST_SLOW_OSC 1'b0
`define LPM_RST_SLEEP_N 1'b1
`define LPM_RST_POWER_SAVE 1'b0
`define LPM_RST_LONG_GAP 1'b0

// ----------------------------------------
// Timing, 8 ns clock period
// ----------------------------------------
`define LPM_CLK_NS 8
`define LPM_PLL_LOCK_NS 1000
`define LPM_PLL_LOCK_CYC ((`LPM_PLL_LOCK_NS + `LPM_CLK_NS - 1) / `LPM_CLK_NS)
`define LPM_SWRST_NS 80
`define LPM_SWRST_CYC ((`LPM_SWRST_NS + `LPM_CLK_NS - 1) / `LPM_CLK_NS)
`define LPM_PULSE_NS 100
`define LPM_PULSE_CYC ((`LPM_PULSE_NS + `LPM_CLK_NS - 1) / `LPM_CLK_NS)
`define LPM_GAP_NS 16000000
`define LPM_GAP_CYC (`LPM_GAP_NS / `LPM_CLK_NS)
`define LPM_LONG_GAP_NS 64000000
`define LPM_LONG_GAP_CYC (`LPM_LONG_GAP_NS / `LPM_CLK_NS)

`endif

// file: common/lpm_pkg.sv
package lpm_pkg;

  typedef enum logic [2:0] {
    st_normal = 3'b000,
    st_save = 3'b001,
    st_sleep = 3'b010,
    st_pdown = 3'b011,
    st_wake = 3'b100
  } lpm_state_t;

endpackage

// file: hw/phy_low_power_mode_control.sv
`timescale 1ns/1ps
`include "lpm_params.svh"

// Overview of operation
// (R1) Power saving needs enable, autoneg, no link
// (R2) Power saving keeps only transmitter, detector, PLL
// (R3) Power saving off after power-up
// (R4) Sleep enabled by low bit, autoneg, no link
// (R5) PLL-off bit stops PLL during sleep
// (R6) Sleep sends periodic link pulses, optional longer
// (R7) Sleep disabled after power-up
// (R8) Power-down stops all but management access
// (R9) Clearing power-down bit leaves power-down
// (R10) Slow-oscillator bit disconnects crystal input
// (R11) Slow oscillator plus power-down: lowest power
// (R12) Controller exits: slow bit, power-down, reset
// (R13) Software reset bit clears itself
// (R14) Restore PLL and clock before line activity
module phy_low_power_mode_control #(
  parameter int GAP_CYC = `LPM_GAP_CYC,
  parameter int LONG_GAP_CYC = `LPM_LONG_GAP_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic link_up_pin,
  input wire logic energy_pin,
  output logic rx_power_on,
  output logic tx_power_on,
  output logic energy_sense_on,
  output logic pll_on,
  output logic crystal_input_enable,
  output logic slow_osc_select,
  output logic link_pulse,
  output logic line_active,
  output logic core_reset
);

  localparam int RST_LIM = `LPM_SWRST_CYC + 1;
  localparam int LOCK_LIM = `LPM_PLL_LOCK_CYC + 2;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic link_meta, link_sync;
  logic energy_meta, energy_sync;

  always_ff @(posedge clk) begin
    if (srst) begin
      link_meta <= 1'b0;
      link_sync <= 1'b0;
      energy_meta <= 1'b0;
      energy_sync <= 1'b0;
    end else begin
      link_meta <= link_up_pin;
      link_sync <= link_meta;
      energy_meta <= energy_pin;
      energy_sync <= energy_meta;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic autoneg, power_down, pll_off, slow_osc;
  logic sleep_n, power_save, long_gap;
  logic [7:0] rst_cnt;
  logic rst_busy;
  logic rst_req;

  assign rst_busy = (rst_cnt != 8'h00);
  assign rst_req = wr && (addr == `LPM_REG_BASIC) && wdata[`LPM_BIT_SOFT_RESET];

  // A reset write returns every control bit to its default
  always_ff @(posedge clk) begin
    if (srst || rst_req) begin
      autoneg <= `LPM_RST_AUTONEG;
      power_down <= `LPM_RST_POWER_DOWN;
      pll_off <= `LPM_RST_PLL_OFF;
      slow_osc <= `LPM_RST_SLOW_OSC;
      sleep_n <= `LPM_RST_SLEEP_N; // see (R7)
      power_save <= `LPM_RST_POWER_SAVE; // see (R3)
      long_gap <= `LPM_RST_LONG_GAP;
    end else if (wr) begin
      case (addr)
        `LPM_REG_BASIC: begin
          autoneg <= wdata[`LPM_BIT_AUTONEG];
          power_down <= wdata[`LPM_BIT_POWER_DOWN]; // see (R8) see (R9)
        end
        `LPM_REG_DIGITAL: pll_off <= wdata[`LPM_BIT_PLL_OFF];
        `LPM_REG_AFE: slow_osc <= wdata[`LPM_BIT_SLOW_OSC];
        `LPM_REG_PULSE: long_gap <= wdata[`LPM_BIT_LONG_GAP];
        `LPM_REG_EXPANDED: sleep_n <= wdata[`LPM_BIT_SLEEP_N]; // see (R4)
        `LPM_REG_CTRL2: power_save <= wdata[`LPM_BIT_POWER_SAVE]; // see (R1)
        default: ;
      endcase
    end
  end

  // Reset bit reads one only while the core reset runs
  always_ff @(posedge clk) begin
    if (srst) begin
      rst_cnt <= 8'h00;
    end else if (rst_req) begin
      rst_cnt <= 8'(`LPM_SWRST_CYC); // see (R13)
    end else if (rst_busy) begin
      rst_cnt <= rst_cnt - 8'h01;
    end
  end

  // ----------------------------------------
  // Mode state machine
  // ----------------------------------------
  lpm_pkg::lpm_state_t state, next_state;
  logic [7:0] lock_cnt;
  logic idle_line;

  // Power saving and sleep only make sense with the cable out
  assign idle_line = autoneg && !link_sync;

  always_comb begin
    next_state = state;
    case (state)
      lpm_pkg::st_normal: begin
        if (!sleep_n && idle_line) begin
          next_state = lpm_pkg::st_sleep; // see (R4)
        end else if (power_save && idle_line) begin
          next_state = lpm_pkg::st_save; // see (R1)
        end
      end
      lpm_pkg::st_save: begin
        if (!sleep_n && idle_line) begin
          next_state = lpm_pkg::st_sleep;
        end else if (!(power_save && idle_line)) begin
          next_state = lpm_pkg::st_normal;
        end
      end
      lpm_pkg::st_sleep: begin
        // Energy on the wire wakes the receiver to look for a link
        if (energy_sync || sleep_n || !idle_line) begin
          next_state = lpm_pkg::st_wake;
        end
      end
      lpm_pkg::st_pdown: begin
        if (!power_down) begin
          next_state = lpm_pkg::st_wake; // see (R9)
        end
      end
      lpm_pkg::st_wake: begin
        if (!slow_osc && lock_cnt == 8'h00) begin
          next_state = lpm_pkg::st_normal; // see (R14)
        end
      end
      default: next_state = lpm_pkg::st_wake;
    endcase
    if (power_down) begin
      next_state = lpm_pkg::st_pdown; // see (R8)
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= lpm_pkg::st_wake;
    end else begin
      state <= next_state;
    end
  end

  // PLL lock wait restarts while the clock path is still off
  always_ff @(posedge clk) begin
    if (srst) begin
      lock_cnt <= 8'(`LPM_PLL_LOCK_CYC);
    end else if (!pll_on || slow_osc || state != lpm_pkg::st_wake) begin
      lock_cnt <= 8'(`LPM_PLL_LOCK_CYC); // see (R14)
    end else if (lock_cnt != 8'h00) begin
      lock_cnt <= lock_cnt - 8'h01;
    end
  end

  // ----------------------------------------
  // Link pulses during sleep
  // ----------------------------------------
  logic [31:0] gap_cnt;
  logic [7:0] pulse_cnt;

  always_ff @(posedge clk) begin
    if (srst || state != lpm_pkg::st_sleep) begin
      gap_cnt <= 32'h0;
    end else if (gap_cnt == 32'h0) begin
      gap_cnt <= long_gap ? 32'(LONG_GAP_CYC) : 32'(GAP_CYC); // see (R6)
    end else begin
      gap_cnt <= gap_cnt - 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || state != lpm_pkg::st_sleep) begin
      pulse_cnt <= 8'h00;
    end else if (gap_cnt == 32'h0) begin
      pulse_cnt <= 8'(`LPM_PULSE_CYC); // see (R6)
    end else if (pulse_cnt != 8'h00) begin
      pulse_cnt <= pulse_cnt - 8'h01;
    end
  end

  // ----------------------------------------
  // Power domain outputs
  // ----------------------------------------
  logic in_pdown, in_sleep, in_save;
  assign in_pdown = (state == lpm_pkg::st_pdown);
  assign in_sleep = (state == lpm_pkg::st_sleep);
  assign in_save = (state == lpm_pkg::st_save);

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_power_on <= 1'b0;
      tx_power_on <= 1'b0;
      energy_sense_on <= 1'b0;
      pll_on <= 1'b0;
      crystal_input_enable <= 1'b1;
      slow_osc_select <= 1'b0;
      link_pulse <= 1'b0;
      line_active <= 1'b0;
      core_reset <= 1'b1;
    end else begin
      rx_power_on <= !(in_pdown || in_sleep || in_save); // see (R2)
      tx_power_on <= !in_pdown; // see (R8)
      energy_sense_on <= !in_pdown;
      pll_on <= !(in_pdown || (in_sleep && pll_off)); // see (R5) see (R11)
      crystal_input_enable <= !slow_osc; // see (R10)
      slow_osc_select <= slow_osc;
      link_pulse <= in_sleep && pulse_cnt != 8'h00;
      line_active <= (state == lpm_pkg::st_normal) && !rst_busy; // see (R14)
      core_reset <= rst_busy || in_pdown;
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  logic [15:0] next_rdata;

  always_comb begin
    next_rdata = 16'h0000;
    case (addr)
      `LPM_REG_BASIC: begin
        next_rdata[`LPM_BIT_SOFT_RESET] = rst_busy;
        next_rdata[`LPM_BIT_AUTONEG] = autoneg;
        next_rdata[`LPM_BIT_POWER_DOWN] = power_down;
      end
      `LPM_REG_DIGITAL: next_rdata[`LPM_BIT_PLL_OFF] = pll_off;
      `LPM_REG_AFE: next_rdata[`LPM_BIT_SLOW_OSC] = slow_osc;
      `LPM_REG_PULSE: next_rdata[`LPM_BIT_LONG_GAP] = long_gap;
      `LPM_REG_STATUS: begin
        next_rdata = {7'h00, energy_sync, link_sync, line_active,
                      crystal_input_enable, pll_on, rx_power_on, state};
      end
      `LPM_REG_EXPANDED: next_rdata[`LPM_BIT_SLEEP_N] = sleep_n;
      `LPM_REG_CTRL2: next_rdata[`LPM_BIT_POWER_SAVE] = power_save;
      default: next_rdata = 16'h0000;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (srst || !rd) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence reset_write_s;
    wr && addr == `LPM_REG_BASIC && wdata[`LPM_BIT_SOFT_RESET];
  endsequence

  sequence reset_clears_s;
    ##[1:RST_LIM] !rst_busy;
  endsequence

  save_entry_a: assert property ( // see (R1)
    state == lpm_pkg::st_normal && power_save && sleep_n && idle_line && !power_down
    |=> state == lpm_pkg::st_save)
    else $error("power saving not entered");

  save_domains_a: assert property ( // see (R2)
    in_save |=> !rx_power_on && pll_on && tx_power_on && energy_sense_on)
    else $error("wrong blocks powered in power saving");

  reset_defaults_a: assert property ( // see (R3)
    $past(srst) |-> !power_save && sleep_n && state != lpm_pkg::st_save)
    else $error("low-power mode enabled after reset");

  sleep_entry_a: assert property ( // see (R4)
    state == lpm_pkg::st_normal && !sleep_n && idle_line && !power_down
    |=> state == lpm_pkg::st_sleep)
    else $error("sleep not entered");

  pll_stop_a: assert property ( // see (R5)
    in_sleep && pll_off |=> !pll_on && tx_power_on && energy_sense_on)
    else $error("PLL left running in sleep");

  pulse_start_a: assert property ( // see (R6)
    in_sleep && gap_cnt == 32'h0 && next_state == lpm_pkg::st_sleep |=> ##1 link_pulse)
    else $error("no link pulse in sleep");

  pdown_entry_a: assert property ( // see (R8)
    power_down |=> in_pdown ##1 (!rx_power_on && !tx_power_on && !pll_on))
    else $error("power-down not honoured");

  pdown_exit_a: assert property ( // see (R9)
    in_pdown && !power_down |=> state == lpm_pkg::st_wake)
    else $error("power-down not left");

  slow_osc_a: assert property ( // see (R10)
    slow_osc |=> !crystal_input_enable && slow_osc_select)
    else $error("crystal input still connected");

  self_clear_a: assert property ( // see (R13)
    reset_write_s |=> rst_busy ##0 reset_clears_s)
    else $error("software reset bit did not clear");

  wake_order_a: assert property ( // see (R14)
    $rose(line_active) |-> $past(pll_on, LOCK_LIM) && crystal_input_enable)
    else $error("line active before PLL restored");

  lowest_power_a: assert property ( // see (R11)
    in_pdown && slow_osc |=> !pll_on && !crystal_input_enable && !tx_power_on && !rx_power_on)
    else $error("lowest power state not reached");

  reset_restore_a: assert property ( // see (R7)
    reset_write_s |=> sleep_n && !power_save && !power_down && !slow_osc)
    else $error("soft reset left a low-power bit set");

endmodule

// file: test/mgmt_model.sv
`timescale 1ns/1ps
// ------
// Management controller model
// ------
module mgmt_model (
  input wire logic clk,
  output logic [4:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [15:0] rdata
);
  initial begin
    addr = 5'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  task automatic rreg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Slow clock off first, so the core never restarts on it
  task automatic exit_slow();
    wreg(5'h11, 16'h0000);
    wreg(5'h00, 16'h1000);
    wreg(5'h00, 16'h9000);
  endtask
endmodule

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic link_up_pin = 1'b0;
  logic energy_pin = 1'b0;
  logic [4:0] addr;
  logic [15:0] wdata, rdata, v;
  logic wr, rd, rx_power_on, tx_power_on, energy_sense_on, pll_on;
  logic crystal_input_enable, slow_osc_select, link_pulse, line_active, core_reset;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  localparam int GAP = 50;
  localparam int LONG_GAP = 200;
  logic lg;
  logic [4:0] ra [6] = '{5'h00, 5'h10, 5'h11, 5'h13, 5'h18, 5'h1f};
  logic [15:0] rv [6] = '{16'h1000, 16'h0000, 16'h0000, 16'h0000, 16'h0800, 16'h0000};
  always #4 clk = ~clk;
  mgmt_model mgmt_model_inst (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  // Short pulse gaps keep the run brief
  phy_low_power_mode_control #(.GAP_CYC(GAP), .LONG_GAP_CYC(LONG_GAP)) phy_low_power_mode_control_inst (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .link_up_pin(link_up_pin), .energy_pin(energy_pin), .rx_power_on(rx_power_on),
    .tx_power_on(tx_power_on), .energy_sense_on(energy_sense_on), .pll_on(pll_on),
    .crystal_input_enable(crystal_input_enable), .slow_osc_select(slow_osc_select),
    .link_pulse(link_pulse), .line_active(line_active), .core_reset(core_reset));
  // ------
  // Helpers
  // ------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_reg({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    mgmt_model_inst.rreg(a, v);
    chk_reg(v, exp);
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wait_line();
    n = 0;
    while (line_active !== 1'b1 && n < 400) begin
      settle(1);
      n++;
    end
    chk_bit(line_active, 1'b1);
  endtask
  // Quiet time between pulses: one period less the pulse itself
  function automatic logic [15:0] exp_gap(input logic long_sel);
    return 16'((long_sel ? LONG_GAP : GAP) + 1 - 13);
  endfunction
  function automatic logic [15:0] exp_rdval(input logic [4:0] a, input logic [15:0] d);
    case (a)
      5'h13: return d & 16'h0001;
      5'h18: return d & 16'h0800;
      5'h1f: return d & 16'h0400;
      default: return 16'h0000;
    endcase
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_sim();
    end
  end
  // ------
  // Tests
  // ------
  initial begin
    void'($urandom(91));
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    wait_line();
    chk_bit(pll_on, 1'b1);
    rd_chk(5'h14, 16'h0078);
    foreach (ra[i]) rd_chk(ra[i], rv[i]);
    v = $urandom;
    lg = v[0];
    mgmt_model_inst.wreg(5'h13, v);
    rd_chk(5'h13, exp_rdval(5'h13, v));
    mgmt_model_inst.wreg(5'h05, v);
    rd_chk(5'h05, 16'h0000);
    $display("test defaults done");
    v = $urandom | 16'h0400;
    mgmt_model_inst.wreg(5'h1f, v);
    rd_chk(5'h1f, exp_rdval(5'h1f, v));
    settle(6);
    chk_bit(rx_power_on, 1'b0);
    chk_bit(tx_power_on & energy_sense_on & pll_on, 1'b1);
    @(posedge clk) link_up_pin <= 1'b1;
    settle(8);
    chk_bit(rx_power_on, 1'b1);
    $display("test power saving done");
    mgmt_model_inst.wreg(5'h00, 16'h0000);
    mgmt_model_inst.wreg(5'h10, 16'h0010);
    v = $urandom & 16'hf7ff;
    mgmt_model_inst.wreg(5'h18, v);
    @(posedge clk) link_up_pin <= 1'b0;
    settle(8);
    chk_bit(rx_power_on, 1'b1);
    mgmt_model_inst.wreg(5'h00, 16'h1000);
    settle(8);
    chk_bit(rx_power_on | pll_on, 1'b0);
    chk_bit(tx_power_on & energy_sense_on, 1'b1);
    wait (link_pulse === 1'b0);
    settle(1);
    n = 0;
    while (link_pulse !== 1'b1 && n < 250) begin
      settle(1);
      n++;
    end
    n = 0;
    while (link_pulse === 1'b1 && n < 30) begin
      settle(1);
      n++;
    end
    chk_reg(16'(n), 16'h000d);
    n = 0;
    while (link_pulse !== 1'b1 && n < 250) begin
      settle(1);
      n++;
    end
    chk_reg(16'(n), exp_gap(lg));
    @(posedge clk) begin
      energy_pin <= 1'b1;
      link_up_pin <= 1'b1;
    end
    wait_line();
    chk_bit(n >= 125, 1'b1);
    chk_bit(pll_on & crystal_input_enable, 1'b1);
    @(posedge clk) energy_pin <= 1'b0;
    $display("test sleep done");
    mgmt_model_inst.wreg(5'h00, 16'h1800);
    settle(4);
    chk_bit(tx_power_on | rx_power_on | pll_on | energy_sense_on | line_active, 1'b0);
    chk_bit(core_reset, 1'b1);
    rd_chk(5'h00, 16'h1800);
    mgmt_model_inst.wreg(5'h11, 16'h0020);
    settle(4);
    chk_bit(slow_osc_select, 1'b1);
    chk_bit(crystal_input_enable | pll_on, 1'b0);
    rd_chk(5'h14, 16'h0083);
    mgmt_model_inst.exit_slow();
    rd_chk(5'h00, 16'h9000);
    chk_bit(core_reset, 1'b1);
    settle(12);
    rd_chk(5'h00, 16'h1000);
    rd_chk(5'h18, 16'h0800);
    wait_line();
    chk_bit(line_active & pll_on & crystal_input_enable, 1'b1);
    chk_bit(core_reset, 1'b0);
    $display("test power down done");
    end_sim();
  end
endmodule
